// file: src/irq_prio_resolver.sv
// Module: interrupt priority resolver with APB register access
//
// The address map and the APB register port were chosen for this implementation.
module irq_prio_resolver (
  input wire logic MCLK_I,                         // Core clock, 40 MHz
  input wire logic RST_I,                          // Synchronous reset, active high
  input wire logic CE_I,                           // Clock enable, freezes state when low
  input wire logic PSEL_I,                         // APB select
  input wire logic PENABLE_I,                      // APB access phase
  input wire logic PWRITE_I,                       // APB direction
  input wire logic [irq_prio_pkg::ADDR_BITS-1:0] PADDR_I, // APB byte address
  input wire logic [31:0] PWDATA_I,                // APB write data
  output logic [31:0] PRDATA_O,                    // APB read data
  output logic PREADY_O,                           // APB ready
  output logic PSLVERR_O,                          // APB error on unmapped address
  input wire logic NMI_REQ_I,                      // Non-maskable request pin
  input wire logic [irq_prio_pkg::NODE_COUNT-1:0] NODE_REQ_I, // Maskable node pins
  input wire logic ACK_I,                          // Core takes the offered grant
  input wire logic RETI_I,                         // Core returns from service
  output logic GRANT_VALID_O,                      // Grant offered
  output logic GRANT_NMI_O,                        // Offered grant is non-maskable
  output logic [3:0] GRANT_NODE_O,                 // Offered node number
  output logic [15:0] GRANT_VECTOR_O               // Offered vector address
);
  import irq_prio_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic nmi_s1_q, nmi_s2_q;                        // Non-maskable synchroniser
  logic [NODE_COUNT-1:0] req_s1_q, req_s2_q;       // Node synchroniser
  logic [7:0] prio_low_a_q, prio_low_a_d;          // Low priority bits, group A
  logic [7:0] prio_high_a_q, prio_high_a_d;        // High priority bits, group A
  logic [5:0] prio_low_b_q, prio_low_b_d;          // Low priority bits, group B
  logic [5:0] prio_high_b_q, prio_high_b_d;        // High priority bits, group B
  logic [NODE_COUNT-1:0] enable_q, enable_d;       // Node enables
  logic [3:0] active_q, active_d;                  // In-service level stack, one bit per level
  logic nmi_active_q, nmi_active_d;                // Non-maskable routine in service
  logic [3:0] last_node_q, last_node_d;            // Last granted node
  grant_type grant_q, grant_d;                     // Offered grant
  bus_state_type bus_q, bus_d;                     // Bus slave phase
  logic [31:0] rdata_q, rdata_d;                   // Read data register
  logic err_q, err_d;                              // Error response register
  logic [NODE_COUNT-1:0] low_all, high_all;        // Concatenated priority bits
  logic [1:0] level [NODE_COUNT];                  // Per-node level
  logic [NODE_COUNT-1:0] pending;                  // Enabled pending requests
  logic [NODE_COUNT-1:0] enabled_in;               // Synchronised, enabled requests

  // Vector address of a node
  function automatic logic [15:0] node_vector(input logic [3:0] n);
    node_vector = VEC_BASE + (VEC_STEP * {12'h000, n});
  endfunction

  // Highest level in service with bit 2 as valid flag, 0 when idle
  function automatic logic [2:0] top_active(input logic [3:0] act);
    logic [2:0] r;
    r = 3'b000;
    for (int k = 0; k < 4; k++) begin
      if (act[k]) begin
        r = {1'b1, 2'(k)};
      end
    end
    top_active = r;
  endfunction

  // Register indices seen by the bus decoder
  localparam logic [2:0] IDX_LOW_A = 3'h0;  // Low priority bits, group A
  localparam logic [2:0] IDX_HIGH_A = 3'h1; // High priority bits, group A
  localparam logic [2:0] IDX_LOW_B = 3'h2;  // Low priority bits, group B
  localparam logic [2:0] IDX_HIGH_B = 3'h3; // High priority bits, group B
  localparam logic [2:0] IDX_ENABLE = 3'h4; // Node enables
  localparam logic [2:0] IDX_STATUS = 3'h5; // Service state, read only
  localparam logic [2:0] IDX_NONE = 3'h7;   // Unmapped address

  // Register index of a bus address; shared by the read and the write phase
  function automatic logic [2:0] reg_index(input logic [ADDR_BITS-1:0] a);
    logic [2:0] r;
    r = IDX_NONE;
    unique case (a)
      OFS_PRIO_LOW_A: r = IDX_LOW_A;
      OFS_PRIO_HIGH_A: r = IDX_HIGH_A;
      OFS_PRIO_LOW_B: r = IDX_LOW_B;
      OFS_PRIO_HIGH_B: r = IDX_HIGH_B;
      OFS_ENABLE: r = IDX_ENABLE;
      OFS_STATUS: r = IDX_STATUS;
      default: r = IDX_NONE;    // Unaligned or outside the map
    endcase
    reg_index = r;
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Two flops on every request pin before any logic
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      req_s1_q <= '0;
      req_s2_q <= '0;
    end else if (CE_I) begin
      nmi_s1_q <= NMI_REQ_I;
      nmi_s2_q <= nmi_s1_q;
      req_s1_q <= NODE_REQ_I;
      req_s2_q <= req_s1_q;
    end
  end

  // ****************************************************************
  // Level decode
  // ****************************************************************
  assign low_all = {prio_low_b_q, prio_low_a_q};
  assign high_all = {prio_high_b_q, prio_high_a_q};
  assign enabled_in = req_s2_q & enable_q;

  // Per-node level from the high and low bits
  generate
    for (genvar g = 0; g < NODE_COUNT; g++) begin : g_lvl
      assign level[g] = {high_all[g], low_all[g]};
      assign pending[g] = enabled_in[g];
    end
  endgenerate

  // ****************************************************************
  // Arbitration and service tracking
  // ****************************************************************
  // Picks the winner and tracks nesting of routines
  always_comb begin
    logic found;
    logic [1:0] best_lvl;
    logic [3:0] best_node;
    logic [2:0] top;
    found = 1'b0;
    best_lvl = 2'b00;
    best_node = 4'h0;
    top = top_active(active_q);
    grant_d = grant_q;
    active_d = active_q;
    nmi_active_d = nmi_active_q;
    last_node_d = last_node_q;
    // Scan low index first so it wins ties
    for (int n = 0; n < NODE_COUNT; n++) begin
      if (pending[n] && (!found || level[n] > best_lvl)) begin
        found = 1'b1;
        best_lvl = level[n];
        best_node = 4'(n);
      end
    end
    // Return closes the innermost routine
    if (RETI_I) begin
      if (nmi_active_q) begin
        nmi_active_d = 1'b0;
      end else if (top[2]) begin
        active_d[top[1:0]] = 1'b0;
      end
    end
    if (ACK_I && grant_q.valid) begin
      // Core takes the offer; it enters service
      grant_d.valid = 1'b0;
      if (grant_q.nmi) begin
        nmi_active_d = 1'b1;
      end else begin
        active_d[grant_q.level] = 1'b1;
        last_node_d = grant_q.node;
      end
    end else if (!grant_q.valid || grant_q.nmi == 1'b0) begin
      // Refresh a maskable offer every cycle until taken; a non-maskable offer holds
      grant_d.valid = 1'b0;
      if (nmi_s2_q && !nmi_active_q) begin
        grant_d.valid = 1'b1;
        grant_d.nmi = 1'b1;
        grant_d.node = 4'h0;
        grant_d.level = 2'b11;
        grant_d.vector = VEC_NMI;
      end else if (found && !nmi_active_q &&
                   (!top[2] || best_lvl > top[1:0])) begin
        grant_d.valid = 1'b1;
        grant_d.nmi = 1'b0;
        grant_d.node = best_node;
        grant_d.level = best_lvl;
        grant_d.vector = node_vector(best_node);
      end
    end
  end

  // Registers the arbitration state
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      grant_q <= '0;
      active_q <= 4'h0;
      nmi_active_q <= 1'b0;
      last_node_q <= 4'h0;
    end else if (CE_I) begin
      grant_q <= grant_d;
      active_q <= active_d;
      nmi_active_q <= nmi_active_d;
      last_node_q <= last_node_d;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Decodes accesses; answers one cycle into the access phase
  // Writes land only at the edge where ready is seen, as the bus requires
  always_comb begin
    logic [2:0] idx;
    idx = reg_index(PADDR_I);
    prio_low_a_d = prio_low_a_q;
    prio_high_a_d = prio_high_a_q;
    prio_low_b_d = prio_low_b_q;
    prio_high_b_d = prio_high_b_q;
    enable_d = enable_q;
    rdata_d = rdata_q;
    err_d = err_q;
    bus_d = bus_q;
    unique case (bus_q)
      BUS_IDLE: begin
        // Access phase seen: act and raise ready next cycle
        if (PSEL_I && PENABLE_I) begin
          bus_d = BUS_DONE;
          err_d = 1'b0;
          rdata_d = 32'h0000_0000;
          unique case (idx)
            IDX_LOW_A: rdata_d[7:0] = prio_low_a_q;
            IDX_HIGH_A: rdata_d[7:0] = prio_high_a_q;
            IDX_LOW_B: rdata_d[5:0] = prio_low_b_q;
            IDX_HIGH_B: rdata_d[5:0] = prio_high_b_q;
            IDX_ENABLE: rdata_d[13:0] = enable_q;
            IDX_STATUS: begin
              rdata_d[ST_NMI_POS] = nmi_active_q;
              rdata_d[ST_DEPTH_POS +: 4] = active_q;
              rdata_d[ST_NODE_POS +: 4] = last_node_q;
              err_d = PWRITE_I;                 // Read only
            end
            default: begin
              err_d = 1'b1;                     // Unmapped address
            end
          endcase
        end
      end
      BUS_DONE: begin
        // Ready stands at this edge: the write lands and the transfer ends
        bus_d = BUS_IDLE;
        err_d = 1'b0;
        if (PWRITE_I && !err_q) begin
          unique case (idx)
            IDX_LOW_A: prio_low_a_d = PWDATA_I[7:0];
            IDX_HIGH_A: prio_high_a_d = PWDATA_I[7:0];
            IDX_LOW_B: prio_low_b_d = PWDATA_I[5:0];
            IDX_HIGH_B: prio_high_b_d = PWDATA_I[5:0];
            IDX_ENABLE: enable_d = PWDATA_I[13:0];
            default: begin
              // Status and refused words take no write
            end
          endcase
        end
      end
      default: begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  // Registers the bus and register state
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      prio_low_a_q <= PRIO_A_RST;
      prio_high_a_q <= PRIO_A_RST;
      prio_low_b_q <= PRIO_B_RST;
      prio_high_b_q <= PRIO_B_RST;
      enable_q <= ENABLE_RST;
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
      bus_q <= BUS_IDLE;
    end else if (CE_I) begin
      prio_low_a_q <= prio_low_a_d;
      prio_high_a_q <= prio_high_a_d;
      prio_low_b_q <= prio_low_b_d;
      prio_high_b_q <= prio_high_b_d;
      enable_q <= enable_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      bus_q <= bus_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign PRDATA_O = rdata_q;
  assign PREADY_O = bus_q[1];          // One-hot bit of the done phase
  assign PSLVERR_O = err_q;            // Cleared when the done phase ends
  assign GRANT_VALID_O = grant_q.valid;
  assign GRANT_NMI_O = grant_q.nmi;
  assign GRANT_NODE_O = grant_q.node;
  assign GRANT_VECTOR_O = grant_q.vector;

endmodule

// file: src/irq_prio_pkg.sv
// Package: constants and types for the interrupt priority resolver
// Function
// - Each maskable node has programmable four-level priority
// - Non-maskable request outranks every maskable request
// - Priority held in two low/high register pairs
// - Preempt only with strictly higher level
// - Top-level maskable routine never preempted by maskable
// - Highest pending level is granted first
// - Same level resolved by fixed polling order
// - Polling order: node zero first, thirteen last
// - One non-maskable request, fourteen maskable nodes
// - Vectors 0003h step eight; non-maskable 0073h
// - Disabled source is never granted
package irq_prio_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NODE_COUNT = 14;       // Maskable nodes
  localparam int LEVEL_BITS = 2;        // Four levels
  localparam int VEC_BITS = 16;         // Vector address width
  localparam int ADDR_BITS = 12;        // APB address width used

  // ****************************************************************
  // Register offsets (bytes)
  // ****************************************************************
  localparam logic [11:0] OFS_PRIO_LOW_A = 12'h000;  // Low bits, nodes 0..7
  localparam logic [11:0] OFS_PRIO_HIGH_A = 12'h004; // High bits, nodes 0..7
  localparam logic [11:0] OFS_PRIO_LOW_B = 12'h008;  // Low bits, nodes 8..13
  localparam logic [11:0] OFS_PRIO_HIGH_B = 12'h00C; // High bits, nodes 8..13
  localparam logic [11:0] OFS_ENABLE = 12'h010;      // Node enable bits
  localparam logic [11:0] OFS_STATUS = 12'h014;      // Service state, read only

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [7:0] PRIO_A_RST = 8'h00;  // Group A priority reset
  localparam logic [5:0] PRIO_B_RST = 6'h00;  // Group B priority reset
  localparam logic [13:0] ENABLE_RST = 14'h0000; // All nodes disabled
  localparam int GROUP_A_NODES = 8;           // Nodes in group A
  localparam int GROUP_B_NODES = 6;           // Nodes in group B
  localparam int ST_NMI_POS = 0;              // Status: non-maskable active
  localparam int ST_DEPTH_POS = 1;            // Status: active level mask, 4 bits
  localparam int ST_NODE_POS = 8;             // Status: last granted node, 4 bits

  // ****************************************************************
  // Vectors
  // ****************************************************************
  localparam logic [15:0] VEC_BASE = 16'h0003; // Node 0 vector
  localparam logic [15:0] VEC_STEP = 16'h0008; // Spacing between nodes
  localparam logic [15:0] VEC_NMI = 16'h0073;  // Non-maskable vector

  // Grant carried to the core
  typedef struct packed {
    logic valid;          // A grant is being offered
    logic nmi;            // Grant is the non-maskable request
    logic [3:0] node;     // Granted node number
    logic [1:0] level;    // Level of the granted node
    logic [15:0] vector;  // Vector address
  } grant_type;

  // APB request fields
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_type;

  // Bus slave phases
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_type;

endpackage

// file: testbench/irq_prio_resolver_asserts.sv
// Checker: grant and register bus relations at the resolver ports
module irq_prio_resolver_asserts (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [13:0] NODE_REQ_I,
  input wire logic ACK_I,
  input wire logic GRANT_VALID_O,
  input wire logic GRANT_NMI_O,
  input wire logic [3:0] GRANT_NODE_O,
  input wire logic [15:0] GRANT_VECTOR_O
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // Grant relations
  // ****************
  default clocking @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  a_nmi_vector: assert property (
    GRANT_VALID_O && GRANT_NMI_O |-> GRANT_VECTOR_O == 16'h0073) else $error("nmi vector");
  a_node_vector: assert property (
    GRANT_VALID_O && !GRANT_NMI_O |-> GRANT_VECTOR_O == 16'h0003 + {GRANT_NODE_O, 3'h0})
    else $error("node vector");
  a_node_range: assert property (
    GRANT_VALID_O |-> GRANT_NMI_O || GRANT_NODE_O < 4'hE) else $error("node out of range");
  a_nmi_held: assert property (
    GRANT_VALID_O && GRANT_NMI_O && !ACK_I |=> GRANT_VALID_O && GRANT_NMI_O)
    else $error("nmi offer dropped");
  a_ack_closes: assert property (
    GRANT_VALID_O && !GRANT_NMI_O && ACK_I |=> !GRANT_VALID_O || GRANT_NMI_O)
    else $error("offer after ack");
  a_grant_cause: assert property (
    GRANT_VALID_O && !GRANT_NMI_O |-> ((($past(NODE_REQ_I) | $past(NODE_REQ_I, 2)
    | $past(NODE_REQ_I, 3)) >> GRANT_NODE_O) & 14'h0001) != 14'h0000)
    else $error("grant without request");
  // ****************
  // Bus relations
  // ****************
  a_ready_once: assert property (
    PREADY_O |=> !PREADY_O) else $error("ready too long");
  a_ready_time: assert property (
    PSEL_I && $rose(PENABLE_I) |=> PREADY_O) else $error("ready late");
  a_err_map: assert property (
    PREADY_O |-> PSLVERR_O == (PADDR_I[1:0] != 2'b00 || PADDR_I[11:2] > 10'h005
    || PWRITE_I && PADDR_I == 12'h014))
    else $error("error flag wrong");
endmodule

// file: testbench/core_model.sv
// Core model: takes offered grants and returns from service
module core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input irq_prio_pkg::grant_type offer_i,
  input wire logic [2:0] ack_wait_i,
  input wire logic hold_i,
  output logic ack_o,
  output logic reti_o
);
  import irq_prio_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] wait_q;  // Cycles the offer has stood
  logic [3:0] depth_q; // Routines in service
  logic [3:0] svc_q;   // Cycles spent in the innermost routine
  // Ack after a set delay; return after six idle cycles unless held
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    reti_o <= 1'b0;
    if (rst_i) begin
      wait_q <= 3'h0;
      depth_q <= 4'h0;
      svc_q <= 4'h0;
    end else if (offer_i.valid === 1'b1 && !ack_o) begin
      if (wait_q == ack_wait_i) begin
        ack_o <= 1'b1;
        wait_q <= 3'h0;
        depth_q <= depth_q + 4'h1;
        svc_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 3'h1;
      end
    end else if (depth_q != 4'h0 && !hold_i) begin
      // Return late enough that the served request has dropped
      if (svc_q == 4'h6) begin
        reti_o <= 1'b1;
        depth_q <= depth_q - 4'h1;
        svc_q <= 4'h0;
      end else begin
        svc_q <= svc_q + 4'h1;
      end
    end
  end
endmodule

// file: testbench/tb_irq_prio_resolver.sv
// Testbench: resolver against a core model with register traffic
module tb_irq_prio_resolver;
  import irq_prio_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst, nmi_q, hold, ack, reti, pready, pslverr, gvalid, gnmi;
  logic [2:0] ack_wait;
  logic [13:0] req_q, served;
  logic [31:0] prdata;
  logic [3:0] gnode;
  logic [15:0] gvec;
  logic [1:0] lvl [14];
  logic [20:0] exp_q [$];
  logic [32:0] bus_q [$];
  apb_req_type bus;
  grant_type offer;
  int err_total, checked, seed, i, lv;
  int cycles = 0;
  assign offer = '{valid: gvalid, nmi: gnmi, node: gnode, level: 2'h0, vector: gvec};
  irq_prio_resolver irq_prio_resolver_i (
    .MCLK_I(mclk), .RST_I(rst), .CE_I(1'b1), .PSEL_I(bus.sel), .PENABLE_I(bus.enable),
    .PWRITE_I(bus.write), .PADDR_I(bus.addr), .PWDATA_I(bus.wdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .NMI_REQ_I(nmi_q),
    .NODE_REQ_I(req_q & ~served), .ACK_I(ack), .RETI_I(reti), .GRANT_VALID_O(gvalid),
    .GRANT_NMI_O(gnmi), .GRANT_NODE_O(gnode), .GRANT_VECTOR_O(gvec));
  core_model core_model_i (.clk_i(mclk), .rst_i(rst), .offer_i(offer),
    .ack_wait_i(ack_wait), .hold_i(hold), .ack_o(ack), .reti_o(reti));
  // ****************
  // Checks and report
  // ****************
  task automatic fail(input string m);
    err_total++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) fail($sformatf("bus %h wanted %h", got, exp));
  endtask
  task automatic chk_grant(input logic [20:0] got, input logic [20:0] exp);
    checked++;
    if (got !== exp) fail($sformatf("grant %h wanted %h", got, exp));
  endtask
  task automatic test_done();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Expected grant word: nmi flag, node, vector
  function automatic logic [20:0] gexp(input logic n, input int k);
    return n ? {1'b1, 4'h0, 16'h0073} : {1'b0, 4'(k), 16'(16'h0003 + k * 8)};
  endfunction
  // ****************
  // Drivers
  // ****************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    bus_q.push_back(e);
    @(posedge mclk);
    bus <= '{sel: 1'b1, enable: 1'b0, write: w, addr: a, wdata: d};
    @(posedge mclk);
    bus.enable <= 1'b1;
    // Ends on ready; only the bench timeout ends a hung wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    bus <= '0;
  endtask
  // Write all level bits and enables, then read them back
  task automatic prog(input logic [13:0] en);
    logic [31:0] v [5];
    for (int k = 0; k < 5; k++) v[k] = 32'h0;
    for (int k = 0; k < 14; k++) begin
      if (k < 8) v[0][k] = lvl[k][0];
      if (k < 8) v[1][k] = lvl[k][1];
      if (k >= 8) v[2][k - 8] = lvl[k][0];
      if (k >= 8) v[3][k - 8] = lvl[k][1];
    end
    v[4][13:0] = en;
    for (int k = 0; k < 5; k++) apb(1'b1, 12'(k * 4), v[k], 33'h0);
    for (int k = 0; k < 5; k++) apb(1'b0, 12'(k * 4), 32'h0, {1'b0, v[k]});
  endtask
  // Wait for all noted grants, then watch for stray ones
  task automatic settle();
    int n = 0;
    while (exp_q.size() > 0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (exp_q.size() > 0) fail("grant missing");
    repeat (30) @(posedge mclk);
  endtask
  task automatic drain();
    settle();
    req_q <= '0;
    served <= '0;
    nmi_q <= 1'b0;
  endtask
  // ****************
  // Watchers
  // ****************
  always @(posedge mclk) begin
    if (pready === 1'b1 && bus_q.size() > 0) begin
      chk_bus({pslverr, (bus.write || bus_q[0][32]) ? 32'h0 : prdata}, bus_q[0]);
      void'(bus_q.pop_front());
    end
  end
  // A taken grant is compared and its request withdrawn
  always @(posedge mclk) begin
    if (!rst && gvalid === 1'b1 && ack === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected grant");
      else chk_grant({gnmi, gnmi ? 4'h0 : gnode, gvec}, exp_q.pop_front());
      if (gnmi === 1'b1) nmi_q <= 1'b0;
      else served[gnode] <= 1'b1;
    end
  end
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail("timeout");
      test_done();
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    rst = 1'b1;
    bus = '0;
    req_q = '0;
    served = '0;
    nmi_q = 1'b0;
    hold = 1'b0;
    ack_wait = 3'h2;
    err_total = 0;
    checked = 0;
    seed = 75;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) apb(1'b0, 12'(i * 4), 32'h0, 33'h0);
    apb(1'b0, 12'h018, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h014, 32'hFFFF, {1'b1, 32'h0});
    // Random levels, all requested at once, node 7 disabled
    for (i = 0; i < 14; i++) lvl[i] = 2'($random(seed));
    prog(14'h3F7F);
    for (lv = 3; lv >= 0; lv--)
      for (i = 0; i < 14; i++)
        if (i != 7 && lvl[i] == lv) exp_q.push_back(gexp(1'b0, i));
    req_q <= 14'h3FFF;
    drain();
    // Top level in service: nmi preempts, node 0 waits
    ack_wait <= 3'h3;
    hold <= 1'b1;
    lvl = '{default: 2'h0};
    lvl[13] = 2'h3;
    lvl[0] = 2'h3;
    prog(14'h3FFF);
    exp_q.push_back(gexp(1'b0, 13));
    req_q <= 14'h2000;
    settle();
    exp_q.push_back(gexp(1'b1, 0));
    req_q <= 14'h2001;
    nmi_q <= 1'b1;
    settle();
    // Status: non-maskable active, level 3 active, node 13 taken last
    apb(1'b0, 12'h014, 32'h0, {1'b0, 32'h0000_0D11});
    exp_q.push_back(gexp(1'b0, 0));
    hold <= 1'b0;
    drain();
    // Strictly higher level preempts, equal level waits
    ack_wait <= 3'h0;
    hold <= 1'b1;
    lvl = '{default: 2'h0};
    lvl[5] = 2'h1;
    lvl[2] = 2'h1;
    lvl[9] = 2'h2;
    prog(14'h3FFF);
    exp_q.push_back(gexp(1'b0, 5));
    req_q <= 14'h0020;
    settle();
    exp_q.push_back(gexp(1'b0, 9));
    req_q <= 14'h0224;
    settle();
    exp_q.push_back(gexp(1'b0, 2));
    hold <= 1'b0;
    drain();
    test_done();
  end
endmodule

bind irq_prio_resolver irq_prio_resolver_asserts irq_prio_resolver_asserts_i (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .NODE_REQ_I(NODE_REQ_I), .ACK_I(ACK_I), .GRANT_VALID_O(GRANT_VALID_O),
  .GRANT_NMI_O(GRANT_NMI_O), .GRANT_NODE_O(GRANT_NODE_O), .GRANT_VECTOR_O(GRANT_VECTOR_O));
